// ==== src/sacs_defs.svh ====
// timing counts, field positions and reset values of the converter sequencer
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH
`define SACS_CLK_NS 20
`define SACS_SAMPLE_CYC 4'h8
`define SACS_BIT_CYC 4'h9
`define SACS_SETTLE_US 14
`define SACS_SETTLE_CYC (((`SACS_SETTLE_US * 1000) + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`define SACS_MODE_RUN 7
`define SACS_MODE_HWTRG 6
`define SACS_MODE_EDGE_HI 2
`define SACS_MODE_EDGE_LO 1
`define SACS_MODE_CMPEN 0
`define SACS_MODE_RST 8'h00
`define SACS_CHAN_RST 3'h0
`define SACS_RESULT_RST 8'h00
`endif

// ==== src/sacs_pkg.sv ====
// types of the converter sequencer
package sacs_pkg;
   typedef enum logic [1:0]
   {
      SACS_IDLE = 2'b00,
      SACS_WAIT_TRIG = 2'b01,
      SACS_SAMPLE = 2'b10,
      SACS_CONVERT = 2'b11
   } sacs_state_t;
endpackage

// ==== src/sacs_sar.sv ====
// successive approximation register, one bit decided per step
`timescale 1ns/10ps
module sacs_sar
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic step,
   input wire logic comp_in,
   output logic [7:0] code,
   output logic done
);
   logic [7:0] mask;
   logic [7:0] next_code;
   logic [7:0] next_mask;

   always_comb
   begin
      next_code = code;
      next_mask = mask;
      if (start)
      begin
         next_code = 8'h80;
         next_mask = 8'h80;
      end
      else if (step && (mask != 8'h00))
      begin
         // drop the trial bit if the input is below the tap, then try the next one
         next_mask = mask >> 1;
         next_code = (comp_in ? code : (code & ~mask)) | next_mask;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         code <= 8'h00;
         mask <= 8'h00;
      end
      else
      begin
         code <= next_code;
         mask <= next_mask;
      end
   end

   assign done = (mask == 8'h00);
endmodule

// ==== src/sacs_sequencer.sv ====
// control and sequencing of the eight-input 8-bit successive approximation converter
// Operation
// - coinciding result read completes before result store
// - trigger edges ignored during conversion, store cycle included
// - mode/channel write wins, result and interrupt dropped
// - channel write leaves completion flag untouched
// - old channel may complete just before rewrite
// - about one tenth of period spent sampling
// - mode/channel write mid-conversion abandons the conversion, next step per mode in force
// - hardware trigger: one conversion per edge, rewrite waits
// - software start: continuous, rewrite restarts on new channel
// - clearing run bit stops conversion at once
`timescale 1ns/10ps
`include "sacs_defs.svh"
module sacs_sequencer
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic mode_wr,
   input wire logic [7:0] mode_wdata,
   input wire logic chan_wr,
   input wire logic [2:0] chan_wdata,
   input wire logic result_rd,
   input wire logic flag_clr,
   input wire logic ext_trigger_input,
   input wire logic comp_in,
   output logic [7:0] converter_mode_reg,
   output logic [2:0] channel_select_reg,
   output logic [7:0] conversion_result_reg,
   output logic conversion_done_flag,
   output logic conversion_done_irq,
   output logic busy,
   output logic sample_en,
   output logic [7:0] dac_code,
   output logic comparator_settled
);
   sacs_pkg::sacs_state_t state;
   sacs_pkg::sacs_state_t next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [7:0] next_mode;
   logic [2:0] next_chan;
   logic [7:0] next_result;
   logic next_flag;
   logic next_irq;
   logic pend;
   logic next_pend;
   logic [7:0] pend_data;
   logic [7:0] next_pend_data;
   logic trig_prev;
   logic [9:0] settle_cnt;
   logic [9:0] next_settle_cnt;
   logic next_settled;
   logic next_busy;
   logic next_sample_en;
   logic sar_start;
   logic sar_step;
   logic sar_done;
   logic eoc;
   logic reg_wr;
   logic trig_edge;

   // state to enter after a register write, given the mode value in force
   function automatic sacs_pkg::sacs_state_t start_state(input logic [7:0] mode);
      if (!mode[`SACS_MODE_RUN])
         start_state = sacs_pkg::SACS_IDLE;
      else if (mode[`SACS_MODE_HWTRG])
         start_state = sacs_pkg::SACS_WAIT_TRIG;
      else
         start_state = sacs_pkg::SACS_SAMPLE;
   endfunction

   sacs_sar u_sar
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .start(sar_start),
      .step(sar_step),
      .comp_in(comp_in),
      .code(dac_code),
      .done(sar_done)
   );

   assign reg_wr = mode_wr | chan_wr;
   assign eoc = (state == sacs_pkg::SACS_CONVERT) && sar_done;
   // edge select: 01 rising, 10 falling, 11 both, 00 none
   assign trig_edge = (converter_mode_reg[`SACS_MODE_EDGE_LO] && ext_trigger_input && !trig_prev)
      || (converter_mode_reg[`SACS_MODE_EDGE_HI] && !ext_trigger_input && trig_prev);

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_mode = converter_mode_reg;
      next_chan = channel_select_reg;
      next_result = conversion_result_reg;
      next_flag = conversion_done_flag;
      next_irq = 1'b0;
      next_pend = 1'b0;
      next_pend_data = pend_data;
      sar_start = 1'b0;
      sar_step = 1'b0;
      case (state)
         sacs_pkg::SACS_IDLE:
            next_cnt = 4'h0;
         sacs_pkg::SACS_WAIT_TRIG:
         begin
            // edges are only looked at here, never while sampling or converting
            if (trig_edge)
            begin
               next_state = sacs_pkg::SACS_SAMPLE;
               next_cnt = 4'h0;
            end
         end
         sacs_pkg::SACS_SAMPLE:
         begin
            if (cnt == `SACS_SAMPLE_CYC - 4'h1)
            begin
               next_state = sacs_pkg::SACS_CONVERT;
               next_cnt = 4'h0;
               sar_start = 1'b1;
            end
            else
               next_cnt = cnt + 4'h1;
         end
         sacs_pkg::SACS_CONVERT:
         begin
            if (sar_done)
            begin
               next_cnt = 4'h0;
               if (converter_mode_reg[`SACS_MODE_HWTRG])
                  next_state = sacs_pkg::SACS_WAIT_TRIG;
               else
                  next_state = sacs_pkg::SACS_SAMPLE;
            end
            else if (cnt == `SACS_BIT_CYC - 4'h1)
            begin
               sar_step = 1'b1;
               next_cnt = 4'h0;
            end
            else
               next_cnt = cnt + 4'h1;
         end
         default:
            next_state = sacs_pkg::SACS_IDLE;
      endcase
      if (flag_clr)
         next_flag = 1'b0;
      if (eoc && !reg_wr)
      begin
         if (result_rd)
         begin
            // the read sees the old value; the store follows next cycle
            next_pend = 1'b1;
            next_pend_data = dac_code;
         end
         else
         begin
            next_result = dac_code;
            next_flag = 1'b1;
            next_irq = 1'b1;
         end
      end
      if (pend && !reg_wr)
      begin
         next_result = pend_data;
         next_flag = 1'b1;
         next_irq = 1'b1;
      end
      if (mode_wr)
      begin
         next_mode = mode_wdata;
         next_state = start_state(mode_wdata);
         next_cnt = 4'h0;
      end
      if (chan_wr)
      begin
         // the completion flag is deliberately not touched here
         next_chan = chan_wdata;
         if (state != sacs_pkg::SACS_IDLE)
         begin
            next_state = start_state(next_mode);
            next_cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state <= sacs_pkg::SACS_IDLE;
         cnt <= 4'h0;
         converter_mode_reg <= `SACS_MODE_RST;
         channel_select_reg <= `SACS_CHAN_RST;
         conversion_result_reg <= `SACS_RESULT_RST;
         conversion_done_flag <= 1'b0;
         conversion_done_irq <= 1'b0;
         pend <= 1'b0;
         pend_data <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         converter_mode_reg <= next_mode;
         channel_select_reg <= next_chan;
         conversion_result_reg <= next_result;
         conversion_done_flag <= next_flag;
         conversion_done_irq <= next_irq;
         pend <= next_pend;
         pend_data <= next_pend_data;
      end
   end

   always_comb
   begin
      next_busy = (next_state == sacs_pkg::SACS_SAMPLE) || (next_state == sacs_pkg::SACS_CONVERT);
      next_sample_en = (next_state == sacs_pkg::SACS_SAMPLE);
      next_settle_cnt = settle_cnt;
      // settling time after comparator enable, shown for software to poll
      if (!converter_mode_reg[`SACS_MODE_CMPEN])
         next_settle_cnt = 10'h000;
      else if (settle_cnt != 10'(`SACS_SETTLE_CYC))
         next_settle_cnt = settle_cnt + 10'h001;
      next_settled = (next_settle_cnt == 10'(`SACS_SETTLE_CYC));
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         trig_prev <= 1'b0;
         busy <= 1'b0;
         sample_en <= 1'b0;
         settle_cnt <= 10'h000;
         comparator_settled <= 1'b0;
      end
      else
      begin
         trig_prev <= ext_trigger_input;
         busy <= next_busy;
         sample_en <= next_sample_en;
         settle_cnt <= next_settle_cnt;
         comparator_settled <= next_settled;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   AST_READ_FIRST: assert property (
      (eoc && result_rd && !reg_wr) |=> $stable(conversion_result_reg) && !conversion_done_irq)
      else $error("result stored before coinciding read");
   AST_READ_THEN_STORE: assert property (
      (eoc && result_rd && !reg_wr) ##1 !reg_wr |=> conversion_done_irq && conversion_done_flag
      && (conversion_result_reg == $past(dac_code, 2)))
      else $error("deferred result store after coinciding read failed");
   AST_TRIG_IGNORED: assert property (
      (eoc && !reg_wr && converter_mode_reg[`SACS_MODE_HWTRG]) |=> (state == sacs_pkg::SACS_WAIT_TRIG))
      else $error("trigger accepted during conversion end");
   AST_WR_WINS: assert property (
      (eoc && reg_wr && !pend) |=> !conversion_done_irq && $stable(conversion_result_reg))
      else $error("result stored despite coinciding register write");
   AST_FLAG_KEPT: assert property (
      (chan_wr && conversion_done_flag && !flag_clr) |=> conversion_done_flag)
      else $error("channel write cleared completion flag");
   AST_SAMPLE_TENTH: assert property (
      ($rose(sample_en) ##0 (!reg_wr)[*8]) |=> !sample_en && (state == sacs_pkg::SACS_CONVERT))
      else $error("sampling phase not eight cycles");
   AST_RESTART: assert property (
      (mode_wr && mode_wdata[`SACS_MODE_RUN] && !mode_wdata[`SACS_MODE_HWTRG] && busy)
      |=> (state == sacs_pkg::SACS_SAMPLE) && (cnt == 4'h0))
      else $error("mode write did not restart conversion");
   AST_HW_REWRITE: assert property (
      (chan_wr && !mode_wr && busy && converter_mode_reg[`SACS_MODE_HWTRG])
      |=> (state == sacs_pkg::SACS_WAIT_TRIG)
      ##1 (!sample_en || $past(trig_edge) || $past(reg_wr)))
      else $error("channel rewrite did not wait for trigger");
   AST_STOP: assert property (
      (mode_wr && !mode_wdata[`SACS_MODE_RUN]) |=> (state == sacs_pkg::SACS_IDLE) ##1 !busy)
      else $error("clearing run bit did not stop conversion");
   AST_EOC: assert property (
      (eoc && !reg_wr && !result_rd) |=> conversion_done_irq && conversion_done_flag
      && (conversion_result_reg == $past(dac_code)))
      else $error("end of conversion did not store result, flag and interrupt");
endmodule

// ==== dv/sacs_analog_src.sv ====
// behavioural analog sources with sample-and-hold in front of the comparator
`timescale 1ns/10ps
module sacs_analog_src
(
   input wire logic mclk,
   input wire logic sample_en,
   input wire logic [2:0] channel_select_reg,
   input wire logic [7:0] dac_code,
   output logic comp_in
);
   logic [7:0] held = 8'h00;
   logic [7:0] level;
   assign level = (channel_select_reg == 3'h7) ? 8'hff : 8'(channel_select_reg * 8'h24);
   // pins are only seen through the hold switch, never read as a port
   always @(posedge mclk)
      if (sample_en)
         held <= level;
   assign comp_in = (held >= dac_code);
endmodule

// ==== dv/sar_adc_conflict_sequencer_bench.sv ====
// self-checking bench of the converter sequencer
`timescale 1ns/10ps
module sar_adc_conflict_sequencer_bench;
   typedef struct {logic [7:0] mode; logic [2:0] ch; logic lvl; logic run_on;} sacs_row_t;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic mode_wr = 1'b0;
   logic [7:0] mode_wdata = 8'h00;
   logic chan_wr = 1'b0;
   logic [2:0] chan_wdata = 3'h0;
   logic result_rd = 1'b0;
   logic flag_clr = 1'b0;
   logic trig = 1'b0;
   logic comp_in, flag, irq, busy, sample_en, settled;
   logic [7:0] mode_q, result, dac_code, old;
   logic [2:0] chan_q;
   int error_cnt = 0;
   int total_checks = 0;
   int n, s;
   sacs_row_t rows [6] = '{'{8'h81, 3'h0, 1'b0, 1'b1}, '{8'h81, 3'h7, 1'b0, 1'b1},
      '{8'hc3, 3'h3, 1'b1, 1'b0}, '{8'hc5, 3'h5, 1'b0, 1'b0}, '{8'hc7, 3'h6, 1'b1, 1'b0},
      '{8'hc7, 3'h1, 1'b0, 1'b0}};
   always #10 mclk = ~mclk;
   sacs_sequencer i_dut (.mclk(mclk), .reset_n(reset_n), .mode_wr(mode_wr),
      .mode_wdata(mode_wdata), .chan_wr(chan_wr), .chan_wdata(chan_wdata),
      .result_rd(result_rd), .flag_clr(flag_clr), .ext_trigger_input(trig), .comp_in(comp_in),
      .converter_mode_reg(mode_q), .channel_select_reg(chan_q), .conversion_result_reg(result),
      .conversion_done_flag(flag), .conversion_done_irq(irq), .busy(busy),
      .sample_en(sample_en), .dac_code(dac_code), .comparator_settled(settled));
   sacs_analog_src i_src (.mclk(mclk), .sample_en(sample_en), .channel_select_reg(chan_q),
      .dac_code(dac_code), .comp_in(comp_in));
   function automatic logic [7:0] lvl_of(input logic [2:0] ch);
      return (ch == 3'h7) ? 8'hff : 8'(ch * 8'h24);
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic wr_mode(input logic [7:0] v);
      mode_wdata = v;
      mode_wr = 1'b1;
      tick(1);
      mode_wr = 1'b0;
   endtask
   task automatic wr_chan(input logic [2:0] v);
      chan_wdata = v;
      chan_wr = 1'b1;
      tick(1);
      chan_wr = 1'b0;
   endtask
   task automatic wait_irq(output int k, output int smp);
      k = 0;
      smp = 0;
      while (irq !== 1'b1)
      begin
         if (k == 400)
         begin
            error_cnt++;
            $display("BAD irq expected 1 seen timeout");
            print_verdict();
         end
         smp += (sample_en === 1'b1);
         tick(1);
         k++;
      end
   endtask
   task automatic stop_clr;
      wr_mode(8'h01);
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
      check("flag", {7'h0, flag}, 8'h00);
   endtask
   initial
   begin
      tick(4);
      check("rst result", result, 8'h00);
      check("rst mode", mode_q, 8'h00);
      check("rst flag", {6'h0, flag, busy}, 8'h00);
      reset_n = 1'b1;
      wr_mode(8'h01);
      n = 0;
      while (settled !== 1'b1 && n < 800)
      begin
         tick(1);
         n++;
      end
      check("settle", 8'(n > 690 && n < 710), 8'h01);
      if (n == 800)
         print_verdict();
      $display("settle done");
      foreach (rows[i])
      begin
         trig = ~rows[i].lvl;
         wr_chan(rows[i].ch);
         wr_mode(rows[i].mode);
         check("mode", mode_q, rows[i].mode);
         check("chan", {5'h0, chan_q}, {5'h0, rows[i].ch});
         if (!rows[i].run_on)
         begin
            tick(2);
            trig = rows[i].lvl;
         end
         wait_irq(n, s);
         if (rows[i].run_on)
            check("period", 8'(n), 8'h51);
         check("samples", 8'(s), 8'h08);
         check("result", result, lvl_of(rows[i].ch));
         check("flag", {7'h0, flag}, 8'h01);
         tick(20);
         check("busy", {7'h0, busy}, {7'h0, rows[i].run_on});
         stop_clr();
         $display("row %0d done", i);
      end
      wr_chan(3'h2);
      old = result;
      wr_mode(8'h81);
      tick(80);
      result_rd = 1'b1;
      check("read", result, old);
      tick(1);
      result_rd = 1'b0;
      check("held irq", {7'h0, irq}, 8'h00);
      check("held", result, old);
      tick(1);
      check("late irq", {7'h0, irq}, 8'h01);
      check("late", result, lvl_of(3'h2));
      $display("read conflict done");
      stop_clr();
      wr_chan(3'h4);
      wr_mode(8'h81);
      tick(80);
      wr_chan(3'h5);
      check("wr irq", {7'h0, irq}, 8'h00);
      check("wr result", result, lvl_of(3'h2));
      check("wr flag", {7'h0, flag}, 8'h00);
      check("resample", {7'h0, sample_en}, 8'h01);
      wait_irq(n, s);
      check("new period", 8'(n), 8'h51);
      check("new ch", result, lvl_of(3'h5));
      wr_chan(3'h6);
      check("flag kept", {7'h0, flag}, 8'h01);
      tick(40);
      wr_mode(8'h81);
      wait_irq(n, s);
      check("restart", 8'(n), 8'h51);
      check("restart ch", result, lvl_of(3'h6));
      tick(40);
      wr_mode(8'h01);
      check("stop", {7'h0, busy}, 8'h00);
      s = 0;
      repeat (100)
      begin
         tick(1);
         s += (irq !== 1'b0);
      end
      check("no irq", 8'(s), 8'h00);
      $display("write conflict done");
      trig = 1'b0;
      wr_chan(3'h3);
      wr_mode(8'hc3);
      tick(2);
      trig = 1'b1;
      tick(20);
      trig = 1'b0;
      tick(20);
      trig = 1'b1;
      wait_irq(n, s);
      check("hw result", result, lvl_of(3'h3));
      tick(30);
      check("hw idle", {7'h0, busy}, 8'h00);
      trig = 1'b0;
      tick(2);
      trig = 1'b1;
      tick(20);
      wr_chan(3'h5);
      check("hw abort", {7'h0, busy}, 8'h00);
      trig = 1'b0;
      tick(2);
      trig = 1'b1;
      wait_irq(n, s);
      check("hw rewrite period", 8'(n), 8'h52);
      check("hw rewrite ch", result, lvl_of(3'h5));
      $display("trigger done");
      print_verdict();
   end
endmodule
